// file: rtl/dcsb_pkg.sv
package dcsb_pkg;
    // widths of the command words
    localparam int AXIS_W = 8;
    localparam int RATE_W = 32;
    localparam int FAULT_W = 16;
    // queue policy encodings
    localparam logic POLICY_PREEMPT = 1'h0;
    localparam logic POLICY_QUEUED = 1'h1;
    // fault codes reported on the fault code output
    localparam logic [FAULT_W-1:0] FAULT_NONE = 16'h0000;
    localparam logic [FAULT_W-1:0] FAULT_BAD_DECEL = 16'h0001;
    localparam logic [FAULT_W-1:0] FAULT_BAD_JERK = 16'h0002;
    // reset values
    localparam logic [RATE_W-1:0] RATE_RST = 32'h0000_0000;
    localparam logic [AXIS_W-1:0] AXIS_RST = 8'h00;
    // command sequencing states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT,
        ST_RUN,
        ST_DONE,
        ST_ABORT,
        ST_ERR
    } dcsb_state_t;
    // axis state as seen by this command
    typedef enum logic {
        AXIS_IDLE_STANDSTILL,
        AXIS_POINT_MOVE
    } dcsb_axis_t;
endpackage : dcsb_pkg

// file: rtl/dcsb_ramp_if.sv
`timescale 1ns/10ps
// link between the sequencer and the speed ramp
interface dcsb_ramp_if #(parameter int W = 32);
    logic load;
    logic run;
    logic [W-1:0] start_speed;
    logic [W-1:0] decel;
    logic [W-1:0] speed;
    logic at_zero;
    modport ctl(output load, output run, output start_speed, output decel,
                input speed, input at_zero);
    modport ramp(input load, input run, input start_speed, input decel,
                 output speed, output at_zero);
endinterface : dcsb_ramp_if

// file: rtl/dcsb_edge.sv
`timescale 1ns/10ps
// launch request edge finder
module dcsb_edge (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic lvl,
    output logic rise,
    output logic fall
);
    logic prev_r;
    logic prev_nxt;

    // previous level follows the input
    always_comb begin
        prev_nxt = lvl;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    // one-cycle pulses on each transition
    assign rise = lvl && !prev_r;
    assign fall = !lvl && prev_r;
endmodule : dcsb_edge

// file: rtl/dcsb_ramp.sv
`timescale 1ns/10ps
// speed ramp down at a fixed step per task cycle
module dcsb_ramp #(
    parameter int W = 32
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    dcsb_ramp_if.ramp rp
);
    logic [W-1:0] speed_r;
    logic [W-1:0] speed_nxt;

    // load the entry speed, then subtract the step until standstill
    always_comb begin
        speed_nxt = speed_r;
        if (rp.load) begin
            speed_nxt = rp.start_speed;
        end else if (rp.run) begin
            if (speed_r <= rp.decel) begin
                speed_nxt = '0;
            end else begin
                speed_nxt = speed_r - rp.decel;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            speed_r <= '0;
        end else begin
            speed_r <= speed_nxt;
        end
    end

    assign rp.speed = speed_r;
    assign rp.at_zero = (speed_r == '0);
endmodule : dcsb_ramp

// file: rtl/dcsb_top.sv
`timescale 1ns/10ps
// Behaviour
// - slow axis at captured rate to standstill
// - capture parameters on launch rising edge
// - start only on rise; fall ignored
// - rise during execution is ignored
// - rise after completion starts again
// - policy 0 preempts, 1 queues behind
// - finished high when halt completes
// - busy high while executing
// - active high only while controlling axis
// - superseded high when aborted by other
// - error flag plus fault code
// - busy on rise, active one cycle later unless queued behind a busy other
// - preempting command takes axis, older superseded
// - superseded clears on launch fall
// - finished at zero speed, clears on fall
// - error holds until launch falls
// - point-move on start, standstill on finish
module dcsb_top #(
    parameter int AXIS_W = dcsb_pkg::AXIS_W,
    parameter int RATE_W = dcsb_pkg::RATE_W,
    parameter int FAULT_W = dcsb_pkg::FAULT_W
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic launch_req,
    input wire logic [AXIS_W-1:0] axis_sel,
    input wire logic [RATE_W-1:0] decel_rate,
    input wire logic [RATE_W-1:0] jerk_rate,
    input wire logic queue_policy,
    input wire logic [RATE_W-1:0] axis_speed,
    input wire logic other_busy,
    input wire logic other_takeover,
    input wire logic axis_fault,
    input wire logic [FAULT_W-1:0] axis_fault_code,
    output logic finished,
    output logic busy,
    output logic active,
    output logic superseded_flag,
    output logic error_flag,
    output logic [FAULT_W-1:0] fault_code,
    output dcsb_pkg::dcsb_axis_t axis_state,
    output logic [RATE_W-1:0] speed_cmd,
    output logic [AXIS_W-1:0] axis_q,
    output logic [RATE_W-1:0] decel_q,
    output logic [RATE_W-1:0] jerk_q,
    output logic policy_q
);
    ////////////////////////////////////////////////////////////////////////
    logic rise;
    logic fall;
    logic start;
    logic bad_decel;
    logic bad_jerk;
    dcsb_pkg::dcsb_state_t state_r;
    dcsb_pkg::dcsb_state_t state_nxt;
    logic finished_r;
    logic finished_nxt;
    logic busy_r;
    logic busy_nxt;
    logic active_r;
    logic active_nxt;
    logic superseded_r;
    logic superseded_nxt;
    logic error_r;
    logic error_nxt;
    logic [FAULT_W-1:0] fault_r;
    logic [FAULT_W-1:0] fault_nxt;
    dcsb_pkg::dcsb_axis_t axst_r;
    dcsb_pkg::dcsb_axis_t axst_nxt;
    logic [AXIS_W-1:0] axis_r;
    logic [AXIS_W-1:0] axis_nxt;
    logic [RATE_W-1:0] decel_r;
    logic [RATE_W-1:0] decel_nxt;
    logic [RATE_W-1:0] jerk_r;
    logic [RATE_W-1:0] jerk_nxt;
    logic policy_r;
    logic policy_nxt;

    dcsb_ramp_if #(.W(RATE_W)) rp_if ();

    ////////////////////////////////////////////////////////////////////////
    // launch edges
    dcsb_edge u_edge (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .lvl(launch_req),
        .rise(rise),
        .fall(fall)
    );

    // speed ramp that carries out the slowdown
    dcsb_ramp #(.W(RATE_W)) u_ramp (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .rp(rp_if.ramp)
    );

    ////////////////////////////////////////////////////////////////////////
    // a new run may begin only when no halt is executing
    assign start = rise && !busy_r;
    assign bad_decel = (decel_rate == dcsb_pkg::RATE_RST);
    assign bad_jerk = (jerk_rate == dcsb_pkg::RATE_RST);

    // ramp is loaded as the axis is taken, steps while in control
    assign rp_if.load = (state_r == dcsb_pkg::ST_WAIT) && active_nxt;
    assign rp_if.start_speed = axis_speed;
    assign rp_if.decel = decel_r;
    assign rp_if.run = active_r;

    ////////////////////////////////////////////////////////////////////////
    // sequencing of one halt command
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            dcsb_pkg::ST_IDLE, dcsb_pkg::ST_DONE, dcsb_pkg::ST_ABORT,
            dcsb_pkg::ST_ERR: begin
                if (start) begin
                    if (bad_decel || bad_jerk) begin
                        state_nxt = dcsb_pkg::ST_ERR;
                    end else begin
                        state_nxt = dcsb_pkg::ST_WAIT;
                    end
                end else if (state_r != dcsb_pkg::ST_IDLE && !launch_req) begin
                    state_nxt = dcsb_pkg::ST_IDLE;
                end
            end
            dcsb_pkg::ST_WAIT: begin
                if (axis_fault) begin
                    state_nxt = dcsb_pkg::ST_ERR;
                end else if (other_takeover) begin
                    state_nxt = dcsb_pkg::ST_ABORT;
                end else if (policy_r == dcsb_pkg::POLICY_PREEMPT || !other_busy) begin
                    state_nxt = dcsb_pkg::ST_RUN;
                end
            end
            dcsb_pkg::ST_RUN: begin
                if (axis_fault) begin
                    state_nxt = dcsb_pkg::ST_ERR;
                end else if (other_takeover) begin
                    state_nxt = dcsb_pkg::ST_ABORT;
                end else if (rp_if.at_zero) begin
                    state_nxt = dcsb_pkg::ST_DONE;
                end
            end
            default: begin
                state_nxt = dcsb_pkg::ST_IDLE;
            end
        endcase
    end

    // flags follow the next state so they move together
    always_comb begin
        busy_nxt = (state_nxt == dcsb_pkg::ST_WAIT) || (state_nxt == dcsb_pkg::ST_RUN);
        active_nxt = (state_nxt == dcsb_pkg::ST_RUN);
        finished_nxt = (state_nxt == dcsb_pkg::ST_DONE);
        superseded_nxt = (state_nxt == dcsb_pkg::ST_ABORT);
        error_nxt = (state_nxt == dcsb_pkg::ST_ERR);
    end

    // fault word and axis state
    always_comb begin
        fault_nxt = fault_r;
        axst_nxt = axst_r;
        if (start) begin
            fault_nxt = dcsb_pkg::FAULT_NONE;
        end
        if (state_nxt == dcsb_pkg::ST_ERR && state_r != dcsb_pkg::ST_ERR) begin
            if (start && bad_decel) begin
                fault_nxt = dcsb_pkg::FAULT_BAD_DECEL;
            end else if (start && bad_jerk) begin
                fault_nxt = dcsb_pkg::FAULT_BAD_JERK;
            end else begin
                fault_nxt = axis_fault_code;
            end
        end
        if (active_nxt && !active_r) begin
            axst_nxt = dcsb_pkg::AXIS_POINT_MOVE;
        end else if (finished_nxt && !finished_r) begin
            axst_nxt = dcsb_pkg::AXIS_IDLE_STANDSTILL;
        end
    end

    // parameters are captured only on an accepted rise
    always_comb begin
        axis_nxt = axis_r;
        decel_nxt = decel_r;
        jerk_nxt = jerk_r;
        policy_nxt = policy_r;
        if (start) begin
            axis_nxt = axis_sel;
            decel_nxt = decel_rate;
            jerk_nxt = jerk_rate;
            policy_nxt = queue_policy;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r <= dcsb_pkg::ST_IDLE;
            busy_r <= 1'b0;
            active_r <= 1'b0;
            finished_r <= 1'b0;
            superseded_r <= 1'b0;
            error_r <= 1'b0;
            fault_r <= dcsb_pkg::FAULT_NONE;
            axst_r <= dcsb_pkg::AXIS_IDLE_STANDSTILL;
            axis_r <= dcsb_pkg::AXIS_RST;
            decel_r <= dcsb_pkg::RATE_RST;
            jerk_r <= dcsb_pkg::RATE_RST;
            policy_r <= dcsb_pkg::POLICY_PREEMPT;
        end else begin
            state_r <= state_nxt;
            busy_r <= busy_nxt;
            active_r <= active_nxt;
            finished_r <= finished_nxt;
            superseded_r <= superseded_nxt;
            error_r <= error_nxt;
            fault_r <= fault_nxt;
            axst_r <= axst_nxt;
            axis_r <= axis_nxt;
            decel_r <= decel_nxt;
            jerk_r <= jerk_nxt;
            policy_r <= policy_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign finished = finished_r;
    assign busy = busy_r;
    assign active = active_r;
    assign superseded_flag = superseded_r;
    assign error_flag = error_r;
    assign fault_code = fault_r;
    assign axis_state = axst_r;
    assign speed_cmd = rp_if.speed;
    assign axis_q = axis_r;
    assign decel_q = decel_r;
    assign jerk_q = jerk_r;
    assign policy_q = policy_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence good_launch_s;
        start && !bad_decel && !bad_jerk;
    endsequence

    sequence busy_then_active_s;
        busy_r && !active_r ##1 busy_r && active_r;
    endsequence

    launch_busy_a: assert property (
        good_launch_s |=> busy_r && !active_r)
        else $error("busy did not rise one cycle after launch");

    busy_active_a: assert property (
        good_launch_s ##1 (!axis_fault && !other_takeover
            && policy_r == dcsb_pkg::POLICY_PREEMPT) |-> busy_then_active_s)
        else $error("active did not follow busy by one cycle");

    rerise_ignored_a: assert property (
        rise && busy_r |=> $stable(decel_r) && $stable(axis_r) && $stable(jerk_r))
        else $error("parameters changed on a rise during execution");

    end_flags_a: assert property (
        $rose(finished_r) || $rose(superseded_r) || $rose(error_r)
            |-> !busy_r && !active_r)
        else $error("busy or active stayed with an end flag");

    finish_zero_a: assert property (
        $rose(finished_r) |-> rp_if.at_zero
            && axst_r == dcsb_pkg::AXIS_IDLE_STANDSTILL && $past(active_r))
        else $error("finished rose without standstill");

    finish_pulse_a: assert property (
        finished_r && !launch_req |=> !finished_r)
        else $error("finished not cleared with launch low");

    error_hold_a: assert property (
        $fell(error_r) |-> $past(!launch_req) || $past(rise))
        else $error("error cleared while launch high");

    abort_sets_a: assert property (
        busy_r && other_takeover && !axis_fault |=> superseded_r && !busy_r)
        else $error("takeover did not set superseded");

    queue_wait_a: assert property (
        state_r == dcsb_pkg::ST_WAIT && policy_r == dcsb_pkg::POLICY_QUEUED
            && other_busy && !other_takeover && !axis_fault |=> !active_r && busy_r)
        else $error("queued command took the axis early");

    decel_step_a: assert property (
        active_r && !rp_if.at_zero |=> rp_if.speed < $past(rp_if.speed))
        else $error("speed did not fall while active");

    point_move_a: assert property (
        $rose(active_r) |-> axst_r == dcsb_pkg::AXIS_POINT_MOVE)
        else $error("axis state not point move on start");
endmodule : dcsb_top

// file: verification/dcsb_other_model.sv
`timescale 1ns/10ps
// another motion command sharing the same axis
module dcsb_other_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic busy_go,
    input wire logic [7:0] hold_n,
    input wire logic take_go,
    output logic other_busy,
    output logic other_takeover
);
    logic [7:0] cnt_r;
    ////////////////////////////////////////////////////////////////////////////
    // owns the axis for hold_n cycles; takes the axis over one cycle after take_go
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_r <= 8'h00;
            other_takeover <= 1'h0;
        end else begin
            cnt_r <= busy_go ? hold_n : ((cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00);
            other_takeover <= take_go;
        end
    end
    // a queued command must wait while this is high
    assign other_busy = (cnt_r != 8'h00);
endmodule : dcsb_other_model

// file: verification/dcsb_top_tb.sv
`timescale 1ns/10ps
module dcsb_top_tb;
    logic core_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic launch_req = 1'h0;
    logic [7:0] axis_sel = 8'h00;
    logic [31:0] decel_rate = 32'h0;
    logic [31:0] jerk_rate = 32'h0;
    logic queue_policy = 1'h0;
    logic [31:0] axis_speed = 32'h0;
    logic other_busy, other_takeover, finished, busy, active, superseded_flag, error_flag;
    logic axis_fault = 1'h0;
    logic [15:0] axis_fault_code = 16'h0;
    logic [15:0] fault_code;
    dcsb_pkg::dcsb_axis_t axis_state;
    logic [31:0] speed_cmd, decel_q, jerk_q;
    logic [7:0] axis_q;
    logic policy_q;
    logic busy_go = 1'h0;
    logic take_go = 1'h0;
    logic [7:0] hold_n = 8'h00;
    int mismatches = 0;
    int n_compared = 0;
    ////////////////////////////////////////////////////////////////////////////
    // clock, design and the other command
    always #2.5 core_clk = ~core_clk;
    dcsb_top uut (.core_clk, .sys_rst, .launch_req, .axis_sel, .decel_rate, .jerk_rate,
        .queue_policy, .axis_speed, .other_busy, .other_takeover, .axis_fault,
        .axis_fault_code, .finished, .busy, .active, .superseded_flag, .error_flag,
        .fault_code, .axis_state, .speed_cmd, .axis_q, .decel_q, .jerk_q, .policy_q);
    dcsb_other_model partner (.core_clk, .sys_rst, .busy_go, .hold_n, .take_go,
        .other_busy, .other_takeover);
    ////////////////////////////////////////////////////////////////////////////
    // compare and drive helpers
    task automatic chk_flags(input logic [4:0] exp, input string msg);
        n_compared++;
        if ({finished, busy, active, superseded_flag, error_flag} !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t flags %s", $time, msg);
        end
    endtask : chk_flags
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask : chk_word
    task automatic nxt();
        @(posedge core_clk);
        busy_go <= 1'h0;
        take_go <= 1'h0;
        #1;
    endtask : nxt
    task automatic launch(input logic v);
        @(posedge core_clk);
        launch_req <= v;
        #1;
    endtask : launch
    task automatic start(input logic [7:0] ax, input logic [31:0] dec, jrk,
                         input logic pol, input logic [31:0] spd);
        @(posedge core_clk);
        busy_go <= 1'h0;
        axis_sel <= ax;
        decel_rate <= dec;
        jerk_rate <= jrk;
        queue_policy <= pol;
        axis_speed <= spd;
        launch_req <= 1'h1;
        #1;
    endtask : start
    task automatic own(input logic [7:0] n);
        @(posedge core_clk);
        busy_go <= 1'h1;
        hold_n <= n;
        #1;
    endtask : own
    task automatic finish_up();
        int i;
        for (i = 0; i < 40 && !(finished === 1'h1); i++) nxt();
        chk_flags(5'b10000, "no completion");
        launch(1'h0);
        nxt();
    endtask : finish_up
    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_walk();
        own(8'h0C);
        start(8'h03, 32'hA, 32'h5, 1'h0, 32'h14);
        nxt();
        chk_flags(5'b01000, "busy on launch");
        chk_word(32'(axis_q), 32'h3, "axis");
        chk_word(decel_q, 32'hA, "decel");
        chk_word(jerk_q, 32'h5, "jerk");
        chk_word(32'(policy_q), 32'h0, "policy");
        nxt();
        chk_flags(5'b01100, "active next cycle");
        chk_word(32'(axis_state), 32'(dcsb_pkg::AXIS_POINT_MOVE), "state move");
        chk_word(speed_cmd, 32'h14, "ramp start");
        nxt();
        chk_word(speed_cmd, 32'hA, "ramp step");
        nxt();
        chk_word(speed_cmd, 32'h0, "ramp zero");
        nxt();
        chk_flags(5'b10000, "finished");
        chk_word(32'(axis_state), 32'(dcsb_pkg::AXIS_IDLE_STANDSTILL), "state idle");
        nxt();
        chk_flags(5'b10000, "finished held");
        launch(1'h0);
        nxt();
        chk_flags(5'b00000, "finished cleared");
    endtask : t_walk
    task automatic t_ignore();
        start(8'h03, 32'h7, 32'h5, 1'h0, 32'h15);
        nxt();
        @(posedge core_clk);
        launch_req <= 1'h0;
        decel_rate <= 32'h1;
        axis_sel <= 8'h09;
        #1;
        chk_word(speed_cmd, 32'h15, "ramp start");
        launch(1'h1);
        chk_word(speed_cmd, 32'hE, "fall ignored");
        launch(1'h0);
        chk_word(speed_cmd, 32'h7, "rise ignored");
        chk_word(decel_q, 32'h7, "decel kept");
        chk_word(32'(axis_q), 32'h3, "axis kept");
        nxt();
        nxt();
        chk_flags(5'b10000, "finished pulse");
        nxt();
        chk_flags(5'b00000, "pulse one cycle");
        start(8'h03, 32'h7, 32'h5, 1'h0, 32'h15);
        nxt();
        chk_flags(5'b01000, "restart");
        finish_up();
    endtask : t_ignore
    task automatic t_abort();
        start(8'h01, 32'h1, 32'h5, 1'h0, 32'h3E8);
        nxt();
        nxt();
        @(posedge core_clk);
        take_go <= 1'h1;
        #1;
        nxt();
        nxt();
        chk_flags(5'b00010, "superseded");
        nxt();
        chk_flags(5'b00010, "superseded held");
        launch(1'h0);
        nxt();
        chk_flags(5'b00000, "superseded cleared");
    endtask : t_abort
    task automatic t_queued();
        int i;
        own(8'h06);
        start(8'h02, 32'h5, 32'h5, 1'h1, 32'hA);
        for (i = 0; i < 6; i++) begin
            nxt();
            chk_flags(5'b01000, "queued waits");
        end
        for (i = 0; i < 3 && !(active === 1'h1); i++) nxt();
        chk_flags(5'b01100, "queued takes axis");
        chk_word(32'(policy_q), 32'h1, "policy queued");
        finish_up();
    endtask : t_queued
    task automatic t_err(input logic [31:0] dec, jrk, input logic flt, input logic [15:0] code);
        start(8'h04, dec, jrk, 1'h0, 32'h32);
        if (flt) begin
            nxt();
            @(posedge core_clk);
            axis_fault <= 1'h1;
            axis_fault_code <= 16'h00AB;
            #1;
        end
        nxt();
        chk_flags(5'b00001, "error");
        chk_word(32'(fault_code), 32'(code), "fault code");
        nxt();
        chk_flags(5'b00001, "error held");
        @(posedge core_clk);
        launch_req <= 1'h0;
        axis_fault <= 1'h0;
        #1;
        nxt();
        chk_flags(5'b00000, "error cleared");
    endtask : t_err
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'h0;
        nxt();
        chk_flags(5'b00000, "reset flags");
        chk_word(speed_cmd, 32'h0, "reset speed");
        t_walk();
        t_ignore();
        t_abort();
        t_queued();
        t_err(32'h0, 32'h5, 1'h0, dcsb_pkg::FAULT_BAD_DECEL);
        t_err(32'h5, 32'h0, 1'h0, dcsb_pkg::FAULT_BAD_JERK);
        t_err(32'h1, 32'h5, 1'h1, 16'h00AB);
        summarize();
    end
    initial begin
        #20000;
        mismatches++;
        summarize();
    end
endmodule : dcsb_top_tb
